// file: hw/vap_map.vh
// constants for the vector arithmetic and permute unit
`ifndef VAP_MAP_VH
`define VAP_MAP_VH

`define VAP_OP_W 4
`define VAP_OP_LOGE 4'h0
`define VAP_OP_FMADD 4'h1
`define VAP_OP_MHADDS 4'h2
`define VAP_OP_MAXUB 4'h3
`define VAP_OP_MAXSB 4'h4
`define VAP_OP_MAXUH 4'h5
`define VAP_OP_MAXSH 4'h6
`define VAP_OP_MAXUW 4'h7
`define VAP_OP_MAXSW 4'h8
`define VAP_OP_MAXFP 4'h9
`define VAP_OP_PERM_L 4'hA
`define VAP_OP_PERM_R 4'hB

`define VAP_QNAN 32'h7FC00000
`define VAP_POS_INF 32'h7F800000
`define VAP_NEG_INF 32'hFF800000
`define VAP_EXP_MAX 8'hFF
`define VAP_EXP_BIAS 12'h07F
`define VAP_DENORM_INT 9'h16B
`define VAP_LOG_EXP_OFS 8'h68
`define VAP_SUM_LEAD 12'h048
`define VAP_SUM_TOP 7'h4A
`define VAP_SUM_W 75
`define VAP_EXP_NONE 12'hED4
`define VAP_HALF_MAX 18'h07FFF
`define VAP_HALF_MIN 18'h38000
`define VAP_PERM_R_BASE 8'h10

`endif

// file: hw/vap_fma_lane.v
// one 32-bit float lane of the fused multiply-add, round to nearest even
`timescale 1ns/1ps
`include "vap_map.vh"

module vap_fma_lane (
    input wire [31:0] a_i,
    input wire [31:0] b_i,
    input wire [31:0] c_i,
    input wire flush_i,
    output reg [31:0] d_o
);

reg [31:0] fa, fb, fc;
reg [23:0] ma, mb, mc;
reg signed [11:0] ea, eb, ec, ep, emax, er, d, rs;
reg [47:0] mp;
reg sp, sbig, ssm, sgn, rnd;
reg [74:0] xp, xc, big, sml, s, t;
reg [6:0] p;
reg [30:0] mag;
reg a_inf, b_inf, c_inf, a_nan, b_nan, c_nan, a_zero, b_zero;
integer i;

always @* begin
    // denormal sources become signed zero in flush mode
    fa = (flush_i && a_i[30:23] == 8'h00) ? {a_i[31], 31'h0} : a_i;
    fb = (flush_i && b_i[30:23] == 8'h00) ? {b_i[31], 31'h0} : b_i;
    fc = (flush_i && c_i[30:23] == 8'h00) ? {c_i[31], 31'h0} : c_i;
    a_nan = fa[30:23] == `VAP_EXP_MAX && fa[22:0] != 23'h0;
    b_nan = fb[30:23] == `VAP_EXP_MAX && fb[22:0] != 23'h0;
    c_nan = fc[30:23] == `VAP_EXP_MAX && fc[22:0] != 23'h0;
    a_inf = fa[30:0] == `VAP_POS_INF;
    b_inf = fb[30:0] == `VAP_POS_INF;
    c_inf = fc[30:0] == `VAP_POS_INF;
    a_zero = fa[30:0] == 31'h0;
    b_zero = fb[30:0] == 31'h0;
    ma = {|fa[30:23], fa[22:0]};
    mb = {|fb[30:23], fb[22:0]};
    mc = {|fc[30:23], fc[22:0]};
    ea = (fa[30:23] == 8'h00) ? 12'h001 : {4'h0, fa[30:23]};
    eb = (fb[30:23] == 8'h00) ? 12'h001 : {4'h0, fb[30:23]};
    ec = (fc[30:23] == 8'h00) ? 12'h001 : {4'h0, fc[30:23]};
    sp = fa[31] ^ fb[31];
    mp = ma * mb;
    ep = (mp == 48'h0) ? `VAP_EXP_NONE : ea + eb - `VAP_EXP_BIAS;
    if (mc == 24'h0)
        ec = `VAP_EXP_NONE;
    xp = {1'b0, mp, 26'h0};
    xc = {2'b00, mc, 49'h0};
    if (ep >= ec) begin
        big = xp;
        sml = xc;
        d = ep - ec;
        emax = ep;
        sbig = sp;
        ssm = fc[31];
    end else begin
        big = xc;
        sml = xp;
        d = ec - ep;
        emax = ec;
        sbig = fc[31];
        ssm = sp;
    end
    // align the smaller addend, folding lost bits into its lsb
    if (d > 12'sd74)
        sml = {74'h0, |sml};
    else
        sml = (sml >> d[6:0]) |
            {74'h0, |(sml << (7'd75 - d[6:0]))};
    if (sbig ^ ssm) begin
        if (big >= sml) begin
            s = big - sml;
            sgn = sbig;
        end else begin
            s = sml - big;
            sgn = ssm;
        end
    end else begin
        s = big + sml;
        sgn = sbig;
    end
    p = 7'h0;
    for (i = 0; i < `VAP_SUM_W; i = i + 1)
        if (s[i])
            p = i[6:0];
    er = emax + $signed({5'h0, p}) - `VAP_SUM_LEAD;
    t = s << (`VAP_SUM_TOP - p);
    rs = 12'sd0;
    if (er <= 12'sd0) begin
        rs = 12'sd1 - er;
        if (rs > 12'sd74)
            t = {74'h0, |t};
        else
            t = (t >> rs[6:0]) | {74'h0, |(t << (7'd75 - rs[6:0]))};
    end
    rnd = t[50] & ((t[49:0] != 50'h0) | t[51]);
    mag = {(er <= 12'sd0) ? 8'h00 : er[7:0], t[73:51]} + {30'h0, rnd};
    if (er >= 12'sd255)
        mag = {`VAP_EXP_MAX, 23'h0};
    if (a_nan || b_nan || c_nan || (a_inf && b_zero) || (b_inf && a_zero) ||
        ((a_inf || b_inf) && c_inf && sp != fc[31]))
        d_o = `VAP_QNAN;
    else if (a_inf || b_inf)
        d_o = {sp, `VAP_EXP_MAX, 23'h0};
    else if (c_inf)
        d_o = fc;
    else if (s == 75'h0)
        d_o = {sp & fc[31], 31'h0};
    else if (flush_i && mag[30:23] == 8'h00)
        d_o = {sgn, 31'h0};
    else
        d_o = {sgn, mag};
end

endmodule

// file: hw/vap_unit.v
// vector arithmetic and permute datapath slice, one-cycle registered result
//
// What this block does
// - log estimate gives an approximate base-two log in each of four lanes.
// - in flush mode denormal float sources, and madd/max results, are zero.
// - shift-left permute outputs bytes sh..sh+15, sh the low address nibble.
// - float multiply-add gives a*b+c per lane, rounded to nearest.
// - halfword multiply-high-add adds product bits 31..15 to c, saturated.
// - any clamping halfword lane sets the sticky saturation bit.
// - integer max picks the larger element for 8/16/32 bits, signed or not.
// - float max of positive and negative zero is positive zero.
// - float max with any NaN lane input returns a quiet NaN.
`timescale 1ns/1ps
`include "vap_map.vh"

module vap_unit (
    input wire clk_i,
    input wire rst_b_i,
    input wire issue_i,
    input wire [3:0] op_i,
    input wire [127:0] src_a_i,
    input wire [127:0] src_b_i,
    input wire [127:0] src_c_i,
    input wire [31:0] addr_a_i,
    input wire [31:0] addr_b_i,
    input wire denormal_flush_mode_i,
    input wire sat_clear_i,
    output wire [127:0] result_o,
    output wire done_o,
    output wire saturation_sticky_bit_o
);

reg [127:0] result_reg, result_next;
reg done_reg;
reg sat_reg, sat_next;
reg [127:0] max_int, log_vec, max_fp, mhadd, perm;
wire [127:0] fma_vec;
reg sat_any, sgn8, sgn16, sgn32;
reg [7:0] xa8, xb8;
reg [15:0] xa16, xb16;
reg [31:0] xa32, xb32, addr_sum;
reg signed [31:0] mh_prod;
reg signed [17:0] mh_sum;
reg [3:0] sh;
reg [7:0] kk;
integer k;

// zero with the same sign for a denormal in flush mode
function [31:0] flush_in;
    input [31:0] x;
    input f;
    begin
        flush_in = (f && x[30:23] == 8'h00) ? {x[31], 31'h0} : x;
    end
endfunction

// coarse log2: exponent plus linear mantissa, packed back to a float
function [31:0] log2_est;
    input [31:0] x;
    reg [8:0] ip;
    reg [22:0] fp;
    reg [31:0] v, m;
    integer q, j;
    begin
        ip = 9'h0;
        fp = 23'h0;
        q = 0;
        for (j = 0; j < 23; j = j + 1)
            if (x[j])
                q = j;
        if (x[30:23] != 8'h00) begin
            ip = {1'b0, x[30:23]} - 9'h07F;
            fp = x[22:0];
        end else begin
            ip = q[8:0] + `VAP_DENORM_INT;
            fp = x[22:0] << (23 - q);
        end
        v = {ip, fp};
        m = v[31] ? (~v + 32'h1) : v;
        q = 0;
        for (j = 0; j < 32; j = j + 1)
            if (m[j])
                q = j;
        m = m << (31 - q);
        if (x[30:23] == `VAP_EXP_MAX && x[22:0] != 23'h0)
            log2_est = `VAP_QNAN;
        else if (x[30:0] == 31'h0)
            log2_est = `VAP_NEG_INF;
        else if (x[31])
            log2_est = `VAP_QNAN;
        else if (x[30:23] == `VAP_EXP_MAX)
            log2_est = `VAP_POS_INF;
        else if (v == 32'h0)
            log2_est = 32'h0;
        else
            log2_est = {v[31], q[7:0] + `VAP_LOG_EXP_OFS, m[30:8]};
    end
endfunction

// float maximum on flushed inputs through an order-preserving key
function [31:0] fmax;
    input [31:0] a;
    input [31:0] b;
    input f;
    reg [31:0] x, y, kx, ky;
    begin
        x = flush_in(a, f);
        y = flush_in(b, f);
        kx = x[31] ? ~x : {1'b1, x[30:0]};
        ky = y[31] ? ~y : {1'b1, y[30:0]};
        if ((x[30:23] == `VAP_EXP_MAX && x[22:0] != 23'h0) ||
            (y[30:23] == `VAP_EXP_MAX && y[22:0] != 23'h0))
            fmax = `VAP_QNAN;
        else
            fmax = (kx >= ky) ? x : y;
    end
endfunction

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : fma_lanes
        vap_fma_lane u_lane (
            .a_i(src_a_i[127 - 32 * g -: 32]),
            .b_i(src_b_i[127 - 32 * g -: 32]),
            .c_i(src_c_i[127 - 32 * g -: 32]),
            .flush_i(denormal_flush_mode_i),
            .d_o(fma_vec[127 - 32 * g -: 32])
        );
    end
endgenerate

// per-lane float log estimate and maximum
always @* begin
    log_vec = 128'h0;
    max_fp = 128'h0;
    for (k = 0; k < 4; k = k + 1) begin
        log_vec[127 - 32 * k -: 32] = log2_est(
            flush_in(src_a_i[127 - 32 * k -: 32], denormal_flush_mode_i)
        );
        max_fp[127 - 32 * k -: 32] = fmax(src_a_i[127 - 32 * k -: 32],
            src_b_i[127 - 32 * k -: 32], denormal_flush_mode_i);
    end
end

// integer maximum; signed compare done unsigned with the msb flipped
always @* begin : int_max_blk
    integer k;
    k = 0;
    sgn8 = (op_i == `VAP_OP_MAXSB);
    sgn16 = (op_i == `VAP_OP_MAXSH);
    sgn32 = (op_i == `VAP_OP_MAXSW);
    max_int = 128'h0;
    xa8 = 8'h0;
    xb8 = 8'h0;
    xa16 = 16'h0;
    xb16 = 16'h0;
    xa32 = 32'h0;
    xb32 = 32'h0;
    case (op_i)
        `VAP_OP_MAXUB, `VAP_OP_MAXSB: begin
            for (k = 0; k < 16; k = k + 1) begin
                xa8 = src_a_i[8 * k +: 8] ^ {sgn8, 7'h0};
                xb8 = src_b_i[8 * k +: 8] ^ {sgn8, 7'h0};
                max_int[8 * k +: 8] = (xa8 >= xb8) ?
                    src_a_i[8 * k +: 8] : src_b_i[8 * k +: 8];
            end
        end
        `VAP_OP_MAXUH, `VAP_OP_MAXSH: begin
            for (k = 0; k < 8; k = k + 1) begin
                xa16 = src_a_i[16 * k +: 16] ^ {sgn16, 15'h0};
                xb16 = src_b_i[16 * k +: 16] ^ {sgn16, 15'h0};
                max_int[16 * k +: 16] = (xa16 >= xb16) ?
                    src_a_i[16 * k +: 16] : src_b_i[16 * k +: 16];
            end
        end
        `VAP_OP_MAXUW, `VAP_OP_MAXSW: begin
            for (k = 0; k < 4; k = k + 1) begin
                xa32 = src_a_i[32 * k +: 32] ^ {sgn32, 31'h0};
                xb32 = src_b_i[32 * k +: 32] ^ {sgn32, 31'h0};
                max_int[32 * k +: 32] = (xa32 >= xb32) ?
                    src_a_i[32 * k +: 32] : src_b_i[32 * k +: 32];
            end
        end
        default: max_int = 128'h0;
    endcase
end

// halfword multiply-high-add with saturation
always @* begin : mh_blk
    integer k;
    k = 0;
    mhadd = 128'h0;
    sat_any = 1'b0;
    mh_prod = 32'sh0;
    mh_sum = 18'sh0;
    for (k = 0; k < 8; k = k + 1) begin
        mh_prod = $signed(src_a_i[16 * k +: 16]) *
            $signed(src_b_i[16 * k +: 16]);
        mh_sum = $signed({mh_prod[31], mh_prod[31:15]}) +
            $signed({{2{src_c_i[16 * k + 15]}}, src_c_i[16 * k +: 16]});
        if (mh_sum > $signed(`VAP_HALF_MAX)) begin
            mhadd[16 * k +: 16] = 16'h7FFF;
            sat_any = 1'b1;
        end else if (mh_sum < $signed(`VAP_HALF_MIN)) begin
            mhadd[16 * k +: 16] = 16'h8000;
            sat_any = 1'b1;
        end else begin
            mhadd[16 * k +: 16] = mh_sum[15:0];
        end
    end
end

// permute control vectors, byte 0 at the top
always @* begin : perm_blk
    integer k;
    k = 0;
    addr_sum = addr_a_i + addr_b_i;
    sh = addr_sum[3:0];
    perm = 128'h0;
    kk = 8'h0;
    for (k = 0; k < 16; k = k + 1) begin
        if (op_i == `VAP_OP_PERM_R)
            perm[127 - 8 * k -: 8] =
                `VAP_PERM_R_BASE - {4'h0, sh} + kk;
        else
            perm[127 - 8 * k -: 8] = {4'h0, sh} + kk;
        kk = kk + 8'h01;
    end
end

always @* begin
    result_next = result_reg;
    if (issue_i) begin
        case (op_i)
            `VAP_OP_LOGE: result_next = log_vec;
            `VAP_OP_FMADD: result_next = fma_vec;
            `VAP_OP_MHADDS: result_next = mhadd;
            `VAP_OP_MAXUB, `VAP_OP_MAXSB, `VAP_OP_MAXUH, `VAP_OP_MAXSH,
            `VAP_OP_MAXUW, `VAP_OP_MAXSW: result_next = max_int;
            `VAP_OP_MAXFP: result_next = max_fp;
            `VAP_OP_PERM_L, `VAP_OP_PERM_R: result_next = perm;
            default: result_next = 128'h0;
        endcase
    end
    // a saturation in the clearing cycle still lands
    sat_next = (sat_reg & ~sat_clear_i) |
        (issue_i && op_i == `VAP_OP_MHADDS && sat_any);
end

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        result_reg <= 128'h0;
        done_reg <= 1'b0;
        sat_reg <= 1'b0;
    end else begin
        result_reg <= result_next;
        done_reg <= issue_i;
        sat_reg <= sat_next;
    end
end

assign result_o = result_reg;
assign done_o = done_reg;
assign saturation_sticky_bit_o = sat_reg;

endmodule

// file: tb/vap_unit_chk.sv
// port assertions for the vector unit
`timescale 1ns/1ps
module vap_unit_chk (
    input wire clk_i,
    input wire rst_b_i,
    input wire issue_i,
    input wire [3:0] op_i,
    input wire [127:0] src_a_i,
    input wire [127:0] src_b_i,
    input wire [31:0] addr_a_i,
    input wire [31:0] addr_b_i,
    input wire sat_clear_i,
    input wire [127:0] result_o,
    input wire done_o,
    input wire saturation_sticky_bit_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire [31:0] ea_w = addr_a_i + addr_b_i;
    wire [7:0] sh_w = {4'h0, ea_w[3:0]};
    wire [7:0] ua_w = src_a_i[127:120];
    wire [7:0] ub_w = src_b_i[127:120];
    wire [7:0] mu_w = (ua_w > ub_w) ? ua_w : ub_w;
    wire nan_w = (&src_a_i[94:87]) && (|src_a_i[86:64]);
    wire mh_w = issue_i && (op_i == 4'h2);
    wire z_w = (src_a_i[127:96] == 32'h0) && (src_b_i[127:96] == 32'h80000000);
    done_pulse_a: assert property (issue_i |=> done_o)
        else $error("done missing");
    result_hold_a: assert property (!issue_i |=> $stable(result_o))
        else $error("result moved");
    perm_left_a: assert property (issue_i && op_i == 4'hA |=>
        result_o[127:120] == $past(sh_w) &&
        result_o[7:0] == $past(sh_w) + 8'h0F) else $error("perm left");
    perm_right_a: assert property (issue_i && op_i == 4'hB |=>
        result_o[127:120] == 8'h10 - $past(sh_w) &&
        result_o[7:0] == 8'h1F - $past(sh_w)) else $error("perm right");
    max_ubyte_a: assert property (issue_i && op_i == 4'h3 |=>
        result_o[127:120] == $past(mu_w)) else $error("byte max");
    fmax_zero_a: assert property (issue_i && op_i == 4'h9 && z_w |=>
        result_o[127:96] == 32'h0) else $error("zero max");
    fmax_nan_a: assert property (issue_i && op_i == 4'h9 && nan_w |=>
        result_o[95:64] == 32'h7FC00000) else $error("nan max");
    sat_keep_a: assert property (saturation_sticky_bit_o &&
        !sat_clear_i |=> saturation_sticky_bit_o) else $error("sat lost");
    sat_clear_a: assert property (sat_clear_i && !mh_w |=>
        !saturation_sticky_bit_o) else $error("sat kept");
endmodule

// file: tb/vap_issuer.sv
// issue-side model feeding operations to the vector unit
`timescale 1ns/1ps
module vap_issuer (
    input wire clk_i,
    input wire done_i,
    input wire [127:0] result_i,
    output reg issue_o,
    output reg [3:0] op_o,
    output reg [127:0] a_o,
    output reg [127:0] b_o,
    output reg [127:0] c_o,
    output reg [31:0] aa_o,
    output reg [31:0] ab_o,
    output reg fl_o
);
    initial begin
        issue_o = 1'b0;
        op_o = 4'h0;
        {a_o, b_o, c_o, aa_o, ab_o, fl_o} = 449'h0;
    end
    task run(input [3:0] op, input [127:0] a, b, c,
        input [31:0] aa, ab, input fl, output [127:0] r, output ok);
        integer n;
        begin
            ok = 1'b0;
            r = 128'h0;
            @(posedge clk_i);
            issue_o <= 1'b1;
            op_o <= op;
            {a_o, b_o, c_o, aa_o, ab_o, fl_o} <= {a, b, c, aa, ab, fl};
            @(posedge clk_i);
            issue_o <= 1'b0;
            // released operands no longer show the old value
            {a_o, b_o, c_o} <= ~{a, b, c};
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                @(negedge clk_i);
                ok = (done_i === 1'b1);
                r = result_i;
            end
        end
    endtask
endmodule

// file: tb/vap_unit_tb.sv
// self-checking bench for the vector unit
`timescale 1ns/1ps
`include "vap_map.vh"
module vap_unit_tb;
    reg clk_i, rst_b_i, sat_clear_i, ok;
    wire is_w, fl_w, dn_w, st_w;
    wire [3:0] op_w;
    wire [127:0] a_w, b_w, c_w, rs_w;
    wire [31:0] aa_w, ab_w;
    integer err_total, num_checks, k, s;
    reg [127:0] r, e, e2, x, y;
    vap_unit i_vap_unit (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .issue_i(is_w), .op_i(op_w), .src_a_i(a_w), .src_b_i(b_w),
        .src_c_i(c_w), .addr_a_i(aa_w), .addr_b_i(ab_w),
        .denormal_flush_mode_i(fl_w), .sat_clear_i(sat_clear_i),
        .result_o(rs_w), .done_o(dn_w), .saturation_sticky_bit_o(st_w));
    vap_issuer i_vap_issuer (.clk_i(clk_i), .done_i(dn_w),
        .result_i(rs_w), .issue_o(is_w), .op_o(op_w), .a_o(a_w),
        .b_o(b_w), .c_o(c_w), .aa_o(aa_w), .ab_o(ab_w), .fl_o(fl_w));
    task check(input [95:0] nm, input [127:0] seen, exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task go(input [3:0] op, input [127:0] a, b, c,
        input [31:0] aa, ab, input fl);
        begin
            i_vap_issuer.run(op, a, b, c, aa, ab, fl, r, ok);
            if (!ok) begin
                err_total = err_total + 1;
                $display("MISMATCH done exp 1 seen 0");
                wrap_up;
            end
        end
    endtask
    task t_perm;
        begin
            for (s = 0; s < 16; s = s + 1) begin
                for (k = 0; k < 16; k = k + 1) begin
                    e[127-8*k -: 8] = s[7:0] + k[7:0];
                    e2[127-8*k -: 8] = 8'h10 - s[7:0] + k[7:0];
                end
                go(`VAP_OP_PERM_L, x, x, x, 32'h13, s - 3, 1'b0);
                check("perm left", r, e);
                go(`VAP_OP_PERM_R, x, x, x, 32'hFFFFFFF0, s, 1'b0);
                check("perm right", r, e2);
            end
            $display("test perm done");
        end
    endtask
    task sat_is(input v);
        begin
            @(negedge clk_i);
            check("sticky", {127'h0, st_w}, {127'h0, v});
        end
    endtask
    task t_mhadd;
        begin
            go(`VAP_OP_MHADDS, 128'h80004000_8000FFFF_00000000_00000000,
                128'h80004000_7FFF0002_00000000_00000000,
                128'h7FFF0001_80000005_00050005_00050005,
                32'h0, 32'h0, 1'b0);
            check("mhadd", r,
                128'h7FFF2001_80000004_00050005_00050005);
            sat_is(1'b1);
            go(`VAP_OP_MHADDS, x, x, x, 32'h0, 32'h0, 1'b0);
            sat_is(1'b1);
            @(posedge clk_i);
            sat_clear_i <= 1'b1;
            @(posedge clk_i);
            sat_clear_i <= 1'b0;
            sat_is(1'b0);
            go(`VAP_OP_MHADDS, x, x, x, 32'h0, 32'h0, 1'b0);
            sat_is(1'b0);
            go(`VAP_OP_MHADDS, 128'h8000, 128'h8000, 128'h7FFF, 32'h0,
                32'h0, 1'b0);
            sat_is(1'b1);
            $display("test mhadd done");
        end
    endtask
    task t_imax;
        begin
            y = {8{16'h807F}};
            e = {8{16'h7F80}};
            for (k = 0; k < 6; k = k + 1) begin
                go(`VAP_OP_MAXUB + k[3:0], y, e, x, 32'h0, 32'h0, 1'b0);
                e2 = k[0] ? e : y;
                if (k < 2)
                    e2 = k[0] ? {16{8'h7F}} : {16{8'h80}};
                check("int max", r, e2);
            end
            $display("test imax done");
        end
    endtask
    task t_float;
        begin
            y = 128'h00000000_7F800001_3F800000_00000001;
            e = 128'h80000000_3F800000_40000000_80000000;
            e2 = 128'h00000000_7FC00000_40000000_00000000;
            go(`VAP_OP_MAXFP, y, e, x, 32'h0, 32'h0, 1'b1);
            check("fmax", r, e2);
            go(`VAP_OP_MAXFP, e, y, x, 32'h0, 32'h0, 1'b1);
            check("fmax swap", r, e2);
            for (k = 0; k < 2; k = k + 1) begin
                go(`VAP_OP_FMADD, 128'h3F800000_C0400000_3F800000_00400000,
                    128'h40000000_40000000_3F800000_3F800000,
                    128'h3F000000_3F800000_33800000_00000000, 32'h0, 32'h0,
                    k[0]);
                e2 = {96'h40200000_C0A00000_3F800000, k[0] ? 32'h0 :
                    32'h00400000};
                check("fmadd", r, e2);
            end
            go(`VAP_OP_LOGE, 128'h40800000_3F000000_40000000_00000001, x,
                x, 32'h0, 32'h0, 1'b1);
            check("log", r,
                128'h40000000_BF800000_3F800000_FF800000);
            go(`VAP_OP_LOGE, 128'h00000001_BF800000_7F800000_00000000, x,
                x, 32'h0, 32'h0, 1'b0);
            check("log raw", r,
                128'hC3150000_7FC00000_7F800000_FF800000);
            $display("test float done");
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        rst_b_i = 1'b0;
        sat_clear_i = 1'b0;
        err_total = 0;
        num_checks = 0;
        x = 128'h0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_perm;
        t_mhadd;
        t_imax;
        t_float;
        wrap_up;
    end
endmodule
bind vap_unit vap_unit_chk i_vap_unit_chk (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .issue_i(issue_i), .op_i(op_i),
    .src_a_i(src_a_i), .src_b_i(src_b_i), .addr_a_i(addr_a_i),
    .addr_b_i(addr_b_i), .sat_clear_i(sat_clear_i),
    .result_o(result_o), .done_o(done_o),
    .saturation_sticky_bit_o(saturation_sticky_bit_o));
